// >>> logic/rge_consts.svh
`ifndef RGE_CONSTS_SVH
`define RGE_CONSTS_SVH

// Register indices; the APB byte address is four times the index
`define RGE_IDX_DATA    5'h00
`define RGE_IDX_MASK    5'h01
`define RGE_IDX_PDIR    5'h02
`define RGE_IDX_PEN     5'h03
`define RGE_IDX_HCFG    5'h04
`define RGE_IDX_STATUS  5'h05
`define RGE_IDX_SWRST   5'h1C

// Status and software reset register fields
`define RGE_ST_GP_BIT    0
`define RGE_ST_DRV_BIT   1
`define RGE_ST_USID_LO   4
`define RGE_ST_USID_HI   7
`define RGE_SWRST_BIT    0

// Unique slave identifiers selected by the address strap
`define RGE_USID_ADR_LOW   4'h1
`define RGE_USID_ADR_HIGH  4'h9

// Reset values
`define RGE_RST_DATA       8'h00
`define RGE_RST_PDIR       8'h00
`define RGE_RST_PEN        8'hFF
`define RGE_RST_HCFG       8'hFF
`define RGE_RST_MASK_GP    8'hFF
`define RGE_RST_MASK_AUTO  8'h00
`define RGE_RST_OE_N       8'hFF
`define RGE_RST_PD         8'hFF

// Serial frame layout
`define RGE_CMD_LAST   4'hC
`define RGE_DATA_LAST  4'h8
`define RGE_TAIL_SEEN  4'h1
`define RGE_CMD_WR     3'h2
`define RGE_CMD_RD     3'h3

`endif

// >>> logic/rge_gpo_top.sv
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "rge_consts.svh"

// Operation
// - Address strap low selects identifier 0001, high selects 1001.
// - Eight outputs, each settable to drive high, drive low or high-impedance.
// - Each output may enable a weak pull-up or weak pull-down.
// - Configuration strap level at power-on picks auto or general mode for all outputs.
// - Auto mode resets outputs high-impedance, pull-down on, data unmasked.
// - Auto mode: writing output data turns the pull-down off.
// - Auto mode: that write enables drivers at once, level per written bit.
// - Auto mode: masking works; pulls and high-impedance stay fixed.
// - Auto mode ignores writes to pull direction, pull enable, high config.
// - General mode resets outputs high-impedance, pull-down on, data masked.
// - General mode: first data write drives all low, pull-down kept.
// - Supply pin low, power-on reset or software command resets everything.
// - Serial host interface follows the RF front-end bus revision 1.10.
module rge_gpo_top
    import rge_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              core_clk_in,
    input  wire logic              sys_rst_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]       pwdata_in,
    input  wire logic [3:0]        pstrb_in,
    output logic      [31:0]       prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    input  wire logic              rffe_clk_in,
    input  wire logic              rffe_data_in,
    output logic                   rffe_data_out,
    output logic                   rffe_data_oe_n_out,
    input  wire logic              bus_io_supply_reset_pin_in,
    input  wire logic              addr_strap_in,
    input  wire logic              config_strap_in,
    output logic      [7:0]        output_channel_out,
    output logic      [7:0]        output_channel_oe_n_out,
    output logic      [7:0]        weak_pull_up_out,
    output logic      [7:0]        weak_pull_down_out
);

    rge_top_state_t s;
    rge_top_state_t next_s;
    logic [4:0]     pins_sync;

    logic           sclk;
    logic           sdata;
    logic           vio_ok;
    logic           adr_lvl;
    logic           cfg_lvl;
    logic           sclk_fall;
    logic           sclk_rise;
    logic           ssc_start;
    logic [12:0]    cmd_frame;
    logic [8:0]     data_frame;
    logic           link_wr;
    logic [4:0]     link_wa;
    logic [7:0]     link_wd;
    logic [4:0]     apb_idx;
    logic           apb_mapped;
    logic           apb_wr;
    logic           wr;
    logic [4:0]     wa;
    logic [7:0]     wd;
    logic           swrst;
    logic [7:0]     drive;
    logic [7:0]     rd_byte;

    function automatic rge_top_state_t reset_state();
        rge_top_state_t r;
        r            = '0;
        r.link       = RGE_LINK_IDLE;
        r.sd_oe_n    = 1'b1;
        r.data       = `RGE_RST_DATA;
        r.mask       = `RGE_RST_MASK_GP;
        r.pdir       = `RGE_RST_PDIR;
        r.pen        = `RGE_RST_PEN;
        r.hcfg       = `RGE_RST_HCFG;
        r.pin_oe_n   = `RGE_RST_OE_N;
        r.pd         = `RGE_RST_PD;
        return r;
    endfunction : reset_state

    // Constant copy so the asynchronous reset loads constants only
    localparam rge_top_state_t RST_STATE = reset_state();

    // Gaps in the map answer an error and are never written
    function automatic logic is_mapped(input logic [4:0] idx);
        unique case (idx)
            `RGE_IDX_DATA, `RGE_IDX_MASK, `RGE_IDX_PDIR, `RGE_IDX_PEN,
            `RGE_IDX_HCFG, `RGE_IDX_STATUS, `RGE_IDX_SWRST: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    // Status: bit 0 general mode, bit 1 drivers on, top nibble identifier
    function automatic logic [7:0] read_reg(input rge_top_state_t r, input logic [4:0] idx);
        read_reg = 8'h00;
        unique case (idx)
            `RGE_IDX_DATA:  read_reg = r.data;
            `RGE_IDX_MASK:  read_reg = r.mask;
            `RGE_IDX_PDIR:  read_reg = r.pdir;
            `RGE_IDX_PEN:   read_reg = r.pen;
            `RGE_IDX_HCFG:  read_reg = r.hcfg;
            `RGE_IDX_STATUS: begin
                read_reg[`RGE_ST_GP_BIT]                 = ~r.auto_mode;
                read_reg[`RGE_ST_DRV_BIT]                = r.first_done;
                read_reg[`RGE_ST_USID_HI:`RGE_ST_USID_LO] = r.usid;
            end
            default:        read_reg = 8'h00;
        endcase
    endfunction : read_reg

    // Pins and straps arrive from outside the core clock domain
    rge_sync #(
        .W (5)
    ) u_sync (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .async_in    ({config_strap_in, addr_strap_in, bus_io_supply_reset_pin_in,
                       rffe_data_in, rffe_clk_in}),
        .sync_out    (pins_sync)
    );

    assign sclk    = pins_sync[0];
    assign sdata   = pins_sync[1];
    assign vio_ok  = pins_sync[2];
    assign adr_lvl = pins_sync[3];
    assign cfg_lvl = pins_sync[4];

    assign sclk_fall  = s.sclk_q & ~sclk;
    assign sclk_rise  = ~s.sclk_q & sclk;
    assign cmd_frame  = {s.shift, sdata};
    assign data_frame = {s.shift[7:0], sdata};
    assign apb_idx    = paddr_in[6:2];
    assign apb_mapped = (paddr_in[ADDR_W-1:7] == '0) && (paddr_in[1:0] == 2'h0)
                        && is_mapped(apb_idx);
    assign rd_byte    = read_reg(s, s.addr);

    // Sequence start: data pulses high while the serial clock rests low
    assign ssc_start = ~sclk & ~s.sdata_q & sdata & s.sd_oe_n;

    always_comb begin
        next_s         = s;
        next_s.sclk_q  = sclk;
        next_s.sdata_q = sdata;
        link_wr        = 1'b0;
        link_wa        = `RGE_IDX_DATA;
        link_wd        = 8'h00;

        unique case (s.link)
            RGE_LINK_IDLE, RGE_LINK_PARK: begin
                next_s.link = s.link;
            end
            RGE_LINK_SSC: begin
                // A clock rise inside the start pulse means it was no start
                if (sclk_rise) begin
                    next_s.link = RGE_LINK_IDLE;
                end else if (s.sdata_q & ~sdata) begin
                    next_s.link    = RGE_LINK_CMD;
                    next_s.bit_cnt = 4'h0;
                end
            end
            RGE_LINK_CMD: begin
                if (sclk_fall) begin
                    next_s.shift   = cmd_frame[11:0];
                    next_s.bit_cnt = s.bit_cnt + 4'h1;
                    if (s.bit_cnt == `RGE_CMD_LAST) begin
                        next_s.link    = RGE_LINK_PARK;
                        next_s.bit_cnt = 4'h0;
                        next_s.addr    = cmd_frame[5:1];
                        if ((^cmd_frame) && s.taken && (cmd_frame[12:9] == s.usid)) begin
                            if (cmd_frame[8]) begin
                                link_wr = 1'b1;
                                link_wd = {1'b0, cmd_frame[7:1]};
                            end else if (cmd_frame[8:6] == `RGE_CMD_WR) begin
                                next_s.link = RGE_LINK_WDATA;
                            end else if (cmd_frame[8:6] == `RGE_CMD_RD) begin
                                next_s.link = RGE_LINK_RPARK;
                            end
                        end
                    end
                end
            end
            RGE_LINK_WDATA: begin
                if (sclk_fall) begin
                    next_s.shift   = {3'h0, data_frame};
                    next_s.bit_cnt = s.bit_cnt + 4'h1;
                    if (s.bit_cnt == `RGE_DATA_LAST) begin
                        next_s.link = RGE_LINK_PARK;
                        // Bad parity drops the write silently
                        if (^data_frame) begin
                            link_wr = 1'b1;
                            link_wa = s.addr;
                            link_wd = data_frame[8:1];
                        end
                    end
                end
            end
            RGE_LINK_RPARK: begin
                // Master parks the line for one cycle before we drive
                if (sclk_fall) begin
                    next_s.link    = RGE_LINK_RDATA;
                    next_s.tx      = {rd_byte, ~^rd_byte};
                    next_s.bit_cnt = 4'h0;
                end
            end
            RGE_LINK_RDATA: begin
                // Change after the rise so the bit is steady at the master's fall
                if (sclk_rise) begin
                    next_s.sd_oe_n = 1'b0;
                    next_s.sd_out  = s.tx[8];
                    next_s.tx      = {s.tx[7:0], 1'b0};
                    next_s.bit_cnt = s.bit_cnt + 4'h1;
                    if (s.bit_cnt == `RGE_DATA_LAST) begin
                        next_s.link    = RGE_LINK_RTAIL;
                        next_s.bit_cnt = 4'h0;
                    end
                end
            end
            RGE_LINK_RTAIL: begin
                // Drive the park low for one clock, release on its falling edge
                if (sclk_rise) begin
                    next_s.sd_out  = 1'b0;
                    next_s.bit_cnt = `RGE_TAIL_SEEN;
                end else if (sclk_fall && (s.bit_cnt == `RGE_TAIL_SEEN)) begin
                    next_s.sd_oe_n = 1'b1;
                    next_s.link    = RGE_LINK_PARK;
                end
            end
        endcase

        // A new start abandons whatever frame was in progress, unless we are driving the data line
        if (ssc_start) begin
            next_s.link = RGE_LINK_SSC;
        end

        // Straps are read once; moving them later needs a reset
        // straps caught once the supply pin is up
        if (vio_ok && !s.taken) begin
            next_s.taken     = 1'b1;
            next_s.auto_mode = ~cfg_lvl;
            next_s.usid      = adr_lvl ? `RGE_USID_ADR_HIGH : `RGE_USID_ADR_LOW;
            // auto mode unmasked; general mode masked
            next_s.mask      = cfg_lvl ? `RGE_RST_MASK_GP : `RGE_RST_MASK_AUTO;
        end

        // Serial writes win; APB waits a cycle by holding pready low
        wr    = link_wr | apb_wr;
        wa    = link_wr ? link_wa : apb_idx;
        wd    = link_wr ? link_wd : pwdata_in[7:0];
        swrst = 1'b0;

        if (wr && s.taken) begin
            unique case (wa)
                `RGE_IDX_DATA: begin
                    if (s.auto_mode) begin
                        next_s.pen        = 8'h00;
                        next_s.first_done = 1'b1;
                        next_s.data       = (wd & ~s.mask) | (s.data & s.mask);
                    end else if (!s.first_done) begin
                        next_s.first_done = 1'b1;
                        // The written value is discarded on purpose
                        next_s.data       = `RGE_RST_DATA;
                    end else begin
                        next_s.data       = (wd & ~s.mask) | (s.data & s.mask);
                    end
                end
                // masking stays usable in both modes
                `RGE_IDX_MASK: next_s.mask = wd;
                // auto mode ignores pull and high config
                `RGE_IDX_PDIR: if (!s.auto_mode) next_s.pdir = wd;
                `RGE_IDX_PEN:  if (!s.auto_mode) next_s.pen  = wd;
                `RGE_IDX_HCFG: if (!s.auto_mode) next_s.hcfg = wd;
                `RGE_IDX_SWRST: swrst = wd[`RGE_SWRST_BIT];
                default: begin
                end
            endcase
        end

        // supply pin low or software command resets all
        if (!vio_ok || swrst) begin
            next_s        = reset_state();
            // Edge history survives so no false edge follows the reset
            next_s.sclk_q = sclk;
            next_s.sdata_q = sdata;
        end

        // Driven after the first data write unless a high bit meets a disabled high drive
        // high, low or high-impedance per channel
        drive           = {8{next_s.first_done}} & (~next_s.data | next_s.hcfg);
        next_s.pin_oe_n = ~drive;
        next_s.pu       = next_s.pen & next_s.pdir;
        next_s.pd       = next_s.pen & ~next_s.pdir;

        // Read data is captured every selected cycle so it is a flop at the port
        if (psel_in) begin
            next_s.prdata = apb_mapped ? {24'h000000, read_reg(s, apb_idx)} : 32'h00000000;
        end
    end

    // Misaligned or unmapped accesses end with an error
    // APB write only completes in a cycle free of serial writes
    assign pready_out  = ~link_wr;
    assign pslverr_out = psel_in & penable_in & ~apb_mapped;
    assign apb_wr      = psel_in & penable_in & pwrite_in & pstrb_in[0] & apb_mapped & ~link_wr;

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s <= RST_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign prdata_out              = s.prdata;
    assign rffe_data_out           = s.sd_out;
    assign rffe_data_oe_n_out      = s.sd_oe_n;
    assign output_channel_out      = s.data;
    assign output_channel_oe_n_out = s.pin_oe_n;
    assign weak_pull_up_out        = s.pu;
    assign weak_pull_down_out      = s.pd;

endmodule : rge_gpo_top

// >>> logic/rge_pkg.sv
package rge_pkg;

    typedef enum logic [2:0] {
        RGE_LINK_IDLE  = 3'b000,
        RGE_LINK_SSC   = 3'b001,
        RGE_LINK_CMD   = 3'b010,
        RGE_LINK_WDATA = 3'b011,
        RGE_LINK_RPARK = 3'b100,
        RGE_LINK_RDATA = 3'b101,
        RGE_LINK_RTAIL = 3'b110,
        RGE_LINK_PARK  = 3'b111
    } rge_link_state_t;

    typedef struct packed {
        logic            sclk_q;
        logic            sdata_q;
        rge_link_state_t link;
        logic [3:0]      bit_cnt;
        logic [11:0]     shift;
        logic [4:0]      addr;
        logic [8:0]      tx;
        logic            sd_out;
        logic            sd_oe_n;
        logic            taken;
        logic            auto_mode;
        logic            first_done;
        logic [3:0]      usid;
        logic [7:0]      data;
        logic [7:0]      mask;
        logic [7:0]      pdir;
        logic [7:0]      pen;
        logic [7:0]      hcfg;
        logic [7:0]      pin_oe_n;
        logic [7:0]      pu;
        logic [7:0]      pd;
        logic [31:0]     prdata;
    } rge_top_state_t;

endpackage : rge_pkg

// >>> logic/rge_sync.sv
`timescale 1ns/1ns

module rge_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk_in,
    input  wire logic         sys_rst_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } rge_sync_state_t;

    rge_sync_state_t s;
    rge_sync_state_t next_s;

    // The first stage feeds only the second, to let metastability settle
    always_comb begin
        next_s        = s;
        next_s.stage1 = async_in;
        next_s.stage2 = s.stage1;
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sync_out = s.stage2;

endmodule : rge_sync

// >>> tb/rge_gpo_asserts.sv
`timescale 1ns/1ns

module rge_gpo_asserts #(
    parameter int ADDR_W = 8
) (
    input  wire logic              core_clk_in,
    input  wire logic              sys_rst_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic              pready_out,
    input  wire logic              pslverr_out,
    input  wire logic              bus_io_supply_reset_pin_in,
    input  wire logic              config_strap_in,
    input  wire logic [7:0]        output_channel_out,
    input  wire logic [7:0]        output_channel_oe_n_out,
    input  wire logic [7:0]        weak_pull_up_out,
    input  wire logic [7:0]        weak_pull_down_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // Checked during reset itself, so the default disable is overridden
    property p_rst_vals;
        disable iff (1'b0)
        sys_rst_in && $past(sys_rst_in) |-> output_channel_oe_n_out == 8'hFF
            && weak_pull_down_out == 8'hFF && weak_pull_up_out == 8'h00;
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("outputs not at reset state");

    // Two sync stages plus margin before the supply reset must show
    property p_supply;
        !bus_io_supply_reset_pin_in [*4] |=> output_channel_oe_n_out == 8'hFF
            && weak_pull_down_out == 8'hFF && weak_pull_up_out == 8'h00;
    endproperty
    a_supply: assert property (p_supply)
        else $error("supply pin low did not reset outputs");

    property p_pulls_excl;
        (weak_pull_up_out & weak_pull_down_out) == 8'h00;
    endproperty
    a_pulls_excl: assert property (p_pulls_excl)
        else $error("pull-up and pull-down both on");

    property p_auto_pd;
        !config_strap_in && output_channel_oe_n_out == 8'h00 |->
            weak_pull_down_out == 8'h00 && weak_pull_up_out == 8'h00;
    endproperty
    a_auto_pd: assert property (p_auto_pd)
        else $error("pulls still on with drivers enabled");

    property p_gp_first;
        config_strap_in && $changed(output_channel_oe_n_out)
            && output_channel_oe_n_out == 8'h00 |->
            output_channel_out == 8'h00 && weak_pull_down_out == 8'hFF;
    endproperty
    a_gp_first: assert property (p_gp_first)
        else $error("first drive not low with pull-down");

    property p_hold;
        $fell(sys_rst_in) |-> (output_channel_oe_n_out == 8'hFF) [*3];
    endproperty
    a_hold: assert property (p_hold)
        else $error("outputs left high-impedance too early");

    property p_unmapped;
        psel_in && penable_in && paddr_in[6:2] inside {[5'h06:5'h1B]} |-> pslverr_out;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access without error");

    property p_pready;
        psel_in && penable_in |-> ##[0:1] pready_out;
    endproperty
    a_pready: assert property (p_pready)
        else $error("access not completed in time");
endmodule : rge_gpo_asserts

bind rge_gpo_top rge_gpo_asserts #(.ADDR_W(ADDR_W)) chk_u (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .paddr_in(paddr_in), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .bus_io_supply_reset_pin_in(bus_io_supply_reset_pin_in),
    .config_strap_in(config_strap_in), .output_channel_out(output_channel_out),
    .output_channel_oe_n_out(output_channel_oe_n_out),
    .weak_pull_up_out(weak_pull_up_out), .weak_pull_down_out(weak_pull_down_out)
);

// >>> tb/rge_gpo_top_bench.sv
`timescale 1ns/1ns
`include "rge_consts.svh"

module rge_gpo_top_bench;
    logic        clk, rst, psel, penable, pwrite, sup, adr, cfg;
    logic [7:0]  paddr, ch, ch_oe_n, pu, pd;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, sclk, m_sd, sd_out, sd_oe_n;
    int          miscompares = 0;
    int          comparisons = 0;
    wire         sd_line = sd_oe_n ? m_sd : sd_out;

    rge_gpo_top dut_u (
        .core_clk_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'h1),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .rffe_clk_in(sclk), .rffe_data_in(sd_line), .rffe_data_out(sd_out),
        .rffe_data_oe_n_out(sd_oe_n), .bus_io_supply_reset_pin_in(sup),
        .addr_strap_in(adr), .config_strap_in(cfg), .output_channel_out(ch),
        .output_channel_oe_n_out(ch_oe_n), .weak_pull_up_out(pu), .weak_pull_down_out(pd)
    );
    rge_host_model host_u (.sdata_in(sd_line), .sclk_out(sclk), .sdata_out(m_sd));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic give_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        comparisons++;
        if (g !== x) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
        end
    endtask : chk

    function automatic logic [7:0] ba(input logic [4:0] i);
        return {1'b0, i, 2'b00};
    endfunction : ba

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            $display("CHECK FAILED %0t bus timeout", $time);
            give_verdict();
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
    endtask : rd

    // Sampled mid-cycle so registered outputs of the last edge have landed
    task automatic pins(input logic [31:0] x);
        @(negedge clk);
        chk({ch_oe_n, ch, pu, pd}, x);
    endtask : pins

    // Register lands a few core cycles after the data parity fall, before the frame ends
    task automatic ser(input logic [3:0] u, input logic [7:0] d);
        host_u.wr_frame(u, `RGE_IDX_DATA, d);
        repeat (8) @(posedge clk);
    endtask : ser

    task automatic boot(input logic a, input logic c);
        @(posedge clk);
        sup <= 1'b0;
        adr <= a;
        cfg <= c;
        repeat (5) @(posedge clk);
        sup <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : boot

    task automatic t_auto;
        logic [31:0] r;
        logic        e;
        pins(32'hFF0000FF);
        rd(ba(`RGE_IDX_STATUS), 32'h10);
        rd(ba(`RGE_IDX_MASK), 32'h0);
        ser(4'h9, 8'h3C);
        pins(32'hFF0000FF);
        ser(4'h1, 8'hA5);
        pins(32'h00A50000);
        wr(ba(`RGE_IDX_PDIR), 32'hFF);
        wr(ba(`RGE_IDX_PEN), 32'hFF);
        wr(ba(`RGE_IDX_HCFG), 32'h0);
        pins(32'h00A50000);
        wr(ba(`RGE_IDX_MASK), 32'h0F);
        wr(ba(`RGE_IDX_DATA), 32'h0);
        pins(32'h00050000);
        apb(1'b0, 8'h18, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        $display("test auto_mode done");
    endtask : t_auto

    task automatic t_gen;
        logic [8:0] q;
        boot(1'b1, 1'b1);
        pins(32'hFF0000FF);
        rd(ba(`RGE_IDX_STATUS), 32'h91);
        rd(ba(`RGE_IDX_MASK), 32'hFF);
        ser(4'h9, 8'h5A);
        pins(32'h000000FF);
        wr(ba(`RGE_IDX_DATA), 32'hFF);
        pins(32'h000000FF);
        wr(ba(`RGE_IDX_PDIR), 32'hFF);
        wr(ba(`RGE_IDX_PEN), 32'hFF);
        wr(ba(`RGE_IDX_HCFG), 32'hFF);
        pins(32'h0000FF00);
        wr(ba(`RGE_IDX_MASK), 32'h0);
        ser(4'h9, 8'h5A);
        pins(32'h005AFF00);
        wr(ba(`RGE_IDX_HCFG), 32'h0F);
        pins(32'h505AFF00);
        host_u.wr0_frame(4'h9, 7'h33);
        pins(32'h3033FF00);
        host_u.rd_frame(4'h9, `RGE_IDX_DATA, q);
        chk({23'h000000, q}, 32'h00000067);
        chk({31'h00000000, sd_oe_n}, 32'h00000001);
        $display("test general_mode done");
    endtask : t_gen

    task automatic t_swrst;
        wr(ba(`RGE_IDX_SWRST), 32'h1);
        pins(32'hFF0000FF);
        repeat (4) @(posedge clk);
        rd(ba(`RGE_IDX_MASK), 32'hFF);
        rd(ba(`RGE_IDX_SWRST), 32'h0);
        $display("test soft_reset done");
    endtask : t_swrst

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        sup = 1'b1;
        adr = 1'b0;
        cfg = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        t_auto();
        t_gen();
        t_swrst();
        give_verdict();
    end
endmodule : rge_gpo_top_bench

// >>> tb/rge_host_model.sv
`timescale 1ns/1ns

module rge_host_model (
    input  wire logic sdata_in,
    output logic      sclk_out,
    output logic      sdata_out
);
    // Clock parked low between frames; the master keeps data low when idle
    initial begin
        sclk_out = 1'b0;
        sdata_out = 1'b0;
    end

    // Data moves on the rising edge so it is steady at the sampling fall
    task automatic put_bit(input logic b);
        sclk_out = 1'b1;
        sdata_out = b;
        #200;
        sclk_out = 1'b0;
        #200;
    endtask : put_bit

    task automatic wr_frame(input logic [3:0] u, input logic [4:0] a, input logic [7:0] d);
        logic [22:0] f;
        f = {u, 3'b010, a, ~^{u, 3'b010, a}, d, ~^d, 1'b0};
        // Step off the core clock edge the caller may have just waited on
        #10;
        sdata_out = 1'b1;
        #200;
        sdata_out = 1'b0;
        #200;
        for (int i = 22; i >= 0; i--) begin
            put_bit(f[i]);
        end
    endtask : wr_frame

    // short register-zero write, seven data bits in the command
    task automatic wr0_frame(input logic [3:0] u, input logic [6:0] d);
        logic [13:0] f;
        f = {u, 1'b1, d, ~^{u, 1'b1, d}, 1'b0};
        #10;
        sdata_out = 1'b1;
        #200;
        sdata_out = 1'b0;
        #200;
        for (int i = 13; i >= 0; i--) begin
            put_bit(f[i]);
        end
    endtask : wr0_frame

    // read: command, park clock, nine bits taken at the falls, tail
    task automatic rd_frame(input logic [3:0] u, input logic [4:0] a, output logic [8:0] q);
        logic [12:0] f;
        f = {u, 3'b011, a, ~^{u, 3'b011, a}};
        #10;
        sdata_out = 1'b1;
        #200;
        sdata_out = 1'b0;
        #200;
        for (int i = 12; i >= 0; i--) begin
            put_bit(f[i]);
        end
        put_bit(1'b0);
        for (int i = 8; i >= 0; i--) begin
            sclk_out = 1'b1;
            #200;
            q[i] = sdata_in;
            sclk_out = 1'b0;
            #200;
        end
        put_bit(1'b0);
    endtask : rd_frame
endmodule : rge_host_model
